// ===== core/psm_consts.svh
// Constants for the processor status monitor: register offsets, field positions, reset values and timing counts.
// Assumes it is included by bare name from the package and from the design modules.
`ifndef PSM_CONSTS_SVH
`define PSM_CONSTS_SVH

// Register offsets on the register port.
`define OFS_CPU1_DUTY_CUR 8'h67
`define OFS_CPU1_DUTY_AVG 8'h68
`define OFS_CPU2_DUTY_CUR 8'h69
`define OFS_CPU2_DUTY_AVG 8'h6a
`define OFS_INPUT_LEVELS 8'h6b
`define OFS_CPU1_VCODE 8'h6c
`define OFS_CPU2_VCODE 8'h6d

// Field positions and widths.
`define VCODE_W 6
`define VCODE_RES_HI 7
`define VCODE_RES_LO 6
`define INPUT_W 8
`define PIN_W 22

// Reset values.
`define DUTY_RESET 8'h00
`define VCODE_RESET 6'h00
`define RDATA_RESET 8'h00

// Duty scale: samples per interval and the top register code.
`define DUTY_STEPS 9'h100
`define DUTY_MAX 8'hff
`define DUTY_LAST_IDX 8'hff

// Timing: clock rate and the least stable time of a voltage code.
`define CLK_MHZ 200
`define VCODE_STABLE_NS 600
`define VCODE_STABLE_CYC 7'((`VCODE_STABLE_NS * `CLK_MHZ + 999) / 1000)

`endif

// ===== core/psm_pkg.sv
// Types shared by the processor status monitor modules.
// Assumes the constants header is on the include path.
`include "psm_consts.svh"

package psm_pkg;

	// One access on the register port.
	typedef struct packed
	{
		logic rd; // One-cycle read strobe.
		logic wr; // One-cycle write strobe.
		logic [7:0] addr; // Register offset.
		logic [7:0] wdata; // Write data.
	} reg_req_t;

	// Read answer of the register port.
	typedef struct packed
	{
		logic valid; // One-cycle answer marker.
		logic [7:0] data; // Read data.
	} reg_rsp_t;

	// Raw pin group, in the order cpu2 code, cpu1 code, inputs, cpu2 alert, cpu1 alert.
	typedef struct packed
	{
		logic [`VCODE_W-1:0] vcode2;
		logic [`VCODE_W-1:0] vcode1;
		logic [`INPUT_W-1:0] inputs_n;
		logic alert2_n;
		logic alert1_n;
	} pins_t;

	// State of the pin synchroniser.
	typedef struct packed
	{
		logic [`PIN_W-1:0] s1;
		logic [`PIN_W-1:0] s2;
		logic [`PIN_W-1:0] s3;
		logic [`PIN_W-1:0] q;
	} sync_state_t;

	// State of the monitor.
	typedef struct packed
	{
		logic [7:0] presc; // Clocks left to the next sample.
		logic [7:0] idx; // Sample index within the interval.
		logic [8:0] cnt1; // Active samples of processor 1.
		logic [8:0] cnt2; // Active samples of processor 2.
		logic seen1; // Processor 1 alert was active at any clock.
		logic seen2; // Processor 2 alert was active at any clock.
		logic [7:0] cur1;
		logic [7:0] avg1;
		logic [7:0] cur2;
		logic [7:0] avg2;
		logic [`VCODE_W-1:0] last1; // Last code seen on processor 1 pins.
		logic [`VCODE_W-1:0] last2;
		logic [6:0] stab1; // Clocks the processor 1 code has held.
		logic [6:0] stab2;
		logic [`VCODE_W-1:0] vc1;
		logic [`VCODE_W-1:0] vc2;
		reg_rsp_t rsp;
	} mon_state_t;

endpackage

// ===== core/pin_sync.sv
// Three-stage pin synchroniser with an agreement filter for all monitor pins.
// Assumes the pins are asynchronous to core_clk and change slowly against it.
`include "psm_consts.svh"

module pin_sync
(
	// Clock and reset.
	input wire logic core_clk,
	input wire logic reset,
	// Raw pins and their filtered levels.
	input wire psm_pkg::pins_t pins,
	output psm_pkg::pins_t levels_ff
);
	import psm_pkg::*;

	sync_state_t st_ff; // All synchroniser state.
	sync_state_t nxt_st; // Next state.

	// Stage one is read only by stage two; a bit is accepted once stages two and three agree.
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.s1 = pins;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		// A bit whose stages two and three still disagree keeps its old filtered level.
		nxt_st.q = (st_ff.q & (st_ff.s2 ^ st_ff.s3)) | (st_ff.s3 & ~(st_ff.s2 ^ st_ff.s3));
	end

	// Reset to all ones so that idle active-low pins read inactive.
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			st_ff <= '1;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign levels_ff = st_ff.q;

endmodule

// ===== core/processor_status_monitor.sv
// Processor status monitor: throttle duty, averaged duty, input levels and voltage codes.
// Assumes a register port driven by a serial front end on core_clk, and pins asynchronous to core_clk.
// How it works
// RULE1: Average becomes old average plus current, halved.
// RULE2: Average updates together with its current register.
// RULE3: Duty n of 256; one means tiny nonzero.
// RULE4: Interval end loads processor two current duty.
// RULE5: Duty write keeps contents, restarts both channels.
// RULE6: Input register bit is one when pin low.
// RULE7: Voltage code in 5:0, reserved 7:6, read-only.
// RULE8: Voltage code loads after 600 ns stable.
// RULE9: Interval end loads processor one current duty.
// RULE10: Count active samples, scaled to 256 steps.
`include "psm_consts.svh"

module processor_status_monitor
(
	// Clock and reset.
	input wire logic core_clk,
	input wire logic reset,
	// Processor and general-purpose pins.
	input wire logic cpu1_throttle_alert_n,
	input wire logic cpu2_throttle_alert_n,
	input wire logic [7:0] input_level_n,
	input wire logic [5:0] cpu1_voltage_code_pin,
	input wire logic [5:0] cpu2_voltage_code_pin,
	// Sampling period minus one, in clocks, from the interval setting.
	input wire logic [7:0] throttle_interval,
	// Register port.
	input wire psm_pkg::reg_req_t reg_req,
	output psm_pkg::reg_rsp_t reg_rsp_ff
);
	import psm_pkg::*;

	pins_t raw_pins; // Pins gathered for the synchroniser.
	pins_t lvl; // Filtered pin levels.
	mon_state_t st_ff; // All monitor state.
	mon_state_t nxt_st; // Next state.
	logic tick; // A sample is taken this clock.
	logic iv_end; // Last sample of the interval is taken this clock.
	logic restart; // Software restarts the capture cycle.
	logic act1; // Processor 1 alert is active.
	logic act2; // Processor 2 alert is active.
	logic [8:0] fin1; // Processor 1 count including this sample.
	logic [8:0] fin2; // Processor 2 count including this sample.
	logic [7:0] duty1; // Processor 1 duty at interval end.
	logic [7:0] duty2; // Processor 2 duty at interval end.

	// Turns an active-sample count into a duty code out of 256.
	function automatic logic [7:0] duty_code(input logic [8:0] cnt, input logic seen);
		logic [7:0] r;
		r = cnt[7:0];
		if (cnt == 9'h000)
		begin
			r = seen ? 8'h01 : 8'h00; // [RULE3]
		end
		else if (cnt >= `DUTY_STEPS)
		begin
			r = `DUTY_MAX; // [RULE3]
		end
		return r;
	endfunction

	// Halved sum of the previous average and the new reading.
	function automatic logic [7:0] avg_of(input logic [7:0] old, input logic [7:0] cur);
		logic [8:0] sum;
		sum = {1'b0, old} + {1'b0, cur};
		return sum[8:1];
	endfunction

	// Voltage-code stability counter, saturating at the stable time.
	function automatic logic [6:0] stab_next(input logic [6:0] cnt, input logic same);
		logic [6:0] r;
		r = 7'h00;
		if (same)
		begin
			r = (cnt == `VCODE_STABLE_CYC) ? cnt : 7'(cnt + 7'h01);
		end
		return r;
	endfunction

	assign raw_pins = '{vcode2: cpu2_voltage_code_pin, vcode1: cpu1_voltage_code_pin,
		inputs_n: input_level_n, alert2_n: cpu2_throttle_alert_n, alert1_n: cpu1_throttle_alert_n};

	// Synchronises and filters every pin.
	pin_sync u_sync
	(
		.core_clk(core_clk),
		.reset(reset),
		.pins(raw_pins),
		.levels_ff(lvl)
	);

	// Sampling, interval and restart decode.
	always_comb
	begin
		act1 = ~lvl.alert1_n;
		act2 = ~lvl.alert2_n;
		tick = (st_ff.presc == 8'h00);
		iv_end = tick && (st_ff.idx == `DUTY_LAST_IDX);
		restart = reg_req.wr && (reg_req.addr == `OFS_CPU1_DUTY_CUR || reg_req.addr == `OFS_CPU2_DUTY_CUR);
		fin1 = 9'(st_ff.cnt1 + {8'h00, act1});
		fin2 = 9'(st_ff.cnt2 + {8'h00, act2});
		duty1 = duty_code(fin1, st_ff.seen1 | act1);
		duty2 = duty_code(fin2, st_ff.seen2 | act2);
	end

	// Next-state logic of the whole monitor.
	always_comb
	begin
		nxt_st = st_ff;
		// Throttle measurement: one sample per period, 256 samples an interval.
		if (restart)
		begin
			// The duty registers keep their values; only the capture restarts.
			nxt_st.presc = throttle_interval; // [RULE5]
			nxt_st.idx = 8'h00; // [RULE5]
			nxt_st.cnt1 = 9'h000;
			nxt_st.cnt2 = 9'h000;
			nxt_st.seen1 = 1'b0;
			nxt_st.seen2 = 1'b0;
		end
		else if (iv_end)
		begin
			nxt_st.presc = throttle_interval;
			nxt_st.idx = 8'h00;
			nxt_st.cnt1 = 9'h000;
			nxt_st.cnt2 = 9'h000;
			nxt_st.seen1 = 1'b0;
			nxt_st.seen2 = 1'b0;
			nxt_st.cur1 = duty1; // [RULE9]
			nxt_st.cur2 = duty2; // [RULE4]
			nxt_st.avg1 = avg_of(st_ff.avg1, duty1); // [RULE1] [RULE2]
			nxt_st.avg2 = avg_of(st_ff.avg2, duty2); // [RULE1] [RULE2]
		end
		else
		begin
			nxt_st.presc = tick ? throttle_interval : 8'(st_ff.presc - 8'h01);
			nxt_st.seen1 = st_ff.seen1 | act1;
			nxt_st.seen2 = st_ff.seen2 | act2;
			if (tick)
			begin
				nxt_st.idx = 8'(st_ff.idx + 8'h01);
				nxt_st.cnt1 = fin1; // [RULE10]
				nxt_st.cnt2 = fin2; // [RULE10]
			end
		end
		// Voltage codes load only after the pins have held for the stable time.
		nxt_st.last1 = lvl.vcode1;
		nxt_st.last2 = lvl.vcode2;
		nxt_st.stab1 = stab_next(st_ff.stab1, lvl.vcode1 == st_ff.last1); // [RULE8]
		nxt_st.stab2 = stab_next(st_ff.stab2, lvl.vcode2 == st_ff.last2); // [RULE8]
		if (st_ff.stab1 == `VCODE_STABLE_CYC)
		begin
			nxt_st.vc1 = st_ff.last1; // [RULE8]
		end
		if (st_ff.stab2 == `VCODE_STABLE_CYC)
		begin
			nxt_st.vc2 = st_ff.last2; // [RULE8]
		end
		// Read answer one clock after the strobe; unmapped offsets read zero.
		nxt_st.rsp.valid = reg_req.rd;
		if (reg_req.rd)
		begin
			unique case (reg_req.addr)
				`OFS_CPU1_DUTY_CUR: nxt_st.rsp.data = st_ff.cur1;
				`OFS_CPU1_DUTY_AVG: nxt_st.rsp.data = st_ff.avg1;
				`OFS_CPU2_DUTY_CUR: nxt_st.rsp.data = st_ff.cur2;
				`OFS_CPU2_DUTY_AVG: nxt_st.rsp.data = st_ff.avg2;
				`OFS_INPUT_LEVELS: nxt_st.rsp.data = ~lvl.inputs_n; // [RULE6]
				`OFS_CPU1_VCODE: nxt_st.rsp.data = {2'b00, st_ff.vc1}; // [RULE7]
				`OFS_CPU2_VCODE: nxt_st.rsp.data = {2'b00, st_ff.vc2}; // [RULE7]
				default: nxt_st.rsp.data = `RDATA_RESET;
			endcase
		end
	end

	// Registers the monitor state.
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			st_ff <= '0;
			st_ff.cur1 <= `DUTY_RESET;
			st_ff.cur2 <= `DUTY_RESET;
			st_ff.vc1 <= `VCODE_RESET;
			st_ff.vc2 <= `VCODE_RESET;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rsp_ff = st_ff.rsp;

	// Checks of the monitor behaviour.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence s_read(logic [7:0] a);
		reg_req.rd && reg_req.addr == a;
	endsequence

	a_avg_halved_sum: assert property (iv_end && !restart // [RULE1]
		|=> st_ff.avg1 == 8'((9'($past(st_ff.avg1)) + 9'(st_ff.cur1)) >> 1))
		else $error("average is not the halved sum");
	a_avg_same_cycle: assert property ($changed(st_ff.avg2) || $changed(st_ff.cur2) // [RULE2]
		|-> $past(iv_end) && !$past(restart))
		else $error("average moved outside an interval end");
	a_duty_zero_one: assert property (iv_end && !restart && fin1 == 9'h000 // [RULE3]
		&& (st_ff.seen1 | act1) |=> st_ff.cur1 == 8'h01)
		else $error("tiny nonzero duty not coded as one");
	a_cpu2_duty_load: assert property (iv_end && !restart |=> st_ff.cur2 == $past(duty2)) // [RULE4]
		else $error("processor two duty not loaded");
	a_write_restart: assert property (restart |=> $stable(st_ff.cur1) && $stable(st_ff.cur2) // [RULE5]
		&& st_ff.idx == 8'h00 && st_ff.cnt2 == 9'h000)
		else $error("duty write did not restart capture cleanly");
	a_input_low_one: assert property (s_read(`OFS_INPUT_LEVELS) // [RULE6]
		|=> reg_rsp_ff.valid && reg_rsp_ff.data == ~$past(lvl.inputs_n))
		else $error("input level bits wrong");
	a_vcode_reserved: assert property (s_read(`OFS_CPU1_VCODE) // [RULE7]
		|=> reg_rsp_ff.data[`VCODE_RES_HI:`VCODE_RES_LO] == 2'b00 && reg_rsp_ff.data[5:0] == $past(st_ff.vc1))
		else $error("voltage code read wrong");
	a_vcode_stable: assert property ($changed(st_ff.vc1) // [RULE8]
		|-> $past(st_ff.stab1) == `VCODE_STABLE_CYC && $past(lvl.vcode1, 2) == st_ff.vc1)
		else $error("voltage code loaded before stable time");
	a_cpu1_duty_load: assert property (iv_end && !restart |=> st_ff.cur1 == $past(duty1)) // [RULE9]
		else $error("processor one duty not loaded");
	a_sample_count: assert property (tick && !iv_end && !restart && act1 // [RULE10]
		|=> st_ff.cnt1 == 9'($past(st_ff.cnt1) + 9'h001))
		else $error("active sample not counted");

endmodule

// ===== test/cpu_pair_model.sv
// Model of the two processors that drive the throttle alerts and voltage codes.
// Assumes the bench commands each pin group; the pins are always driven, never released.
module cpu_pair_model
(
	// Commands from the bench.
	input wire logic alert1_on,
	input wire logic alert2_on,
	input wire logic [5:0] code1,
	input wire logic [5:0] code2,
	// Pins toward the monitor.
	output logic cpu1_throttle_alert_n,
	output logic cpu2_throttle_alert_n,
	output logic [5:0] cpu1_voltage_code_pin,
	output logic [5:0] cpu2_voltage_code_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// Alerts are pulled low while a processor throttles.
	assign cpu1_throttle_alert_n = ~alert1_on;
	assign cpu2_throttle_alert_n = ~alert2_on;
	// Voltage codes follow the commanded values.
	assign cpu1_voltage_code_pin = code1;
	assign cpu2_voltage_code_pin = code2;
endmodule

// ===== test/tb_processor_status_monitor.sv
// Self-checking bench for the processor status monitor over its strobe register port.
// Assumes the design files and the processor pair model are compiled first.
`include "psm_consts.svh"

module tb_processor_status_monitor import psm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0; // Clock at 200 MHz.
	logic reset = 1'b1; // Synchronous reset.
	logic a1 = 1'b0; // Processor 1 throttles.
	logic a2 = 1'b0; // Processor 2 throttles.
	logic [5:0] code1 = 6'h00; // Commanded codes.
	logic [5:0] code2 = 6'h00;
	logic [7:0] input_level_n = 8'h5a; // Raw input pins.
	logic [7:0] throttle_interval = 8'h00; // Sampling period minus one.
	reg_req_t reg_req = '0; // Register request.
	reg_rsp_t reg_rsp_ff; // Register answer.
	logic cpu1_throttle_alert_n;
	logic cpu2_throttle_alert_n;
	logic [5:0] cpu1_voltage_code_pin;
	logic [5:0] cpu2_voltage_code_pin;
	int fails = 0; // Mismatches seen.
	int samples_checked = 0; // Comparisons made.
	logic [7:0] cur1_exp = 8'h00; // Expected register contents.
	logic [7:0] cur2_exp = 8'h00;
	logic [7:0] avg1_exp = 8'h00;
	logic [7:0] avg2_exp = 8'h00;

	processor_status_monitor processor_status_monitor_i (.core_clk(core_clk), .reset(reset),
		.cpu1_throttle_alert_n(cpu1_throttle_alert_n), .cpu2_throttle_alert_n(cpu2_throttle_alert_n),
		.input_level_n(input_level_n), .cpu1_voltage_code_pin(cpu1_voltage_code_pin),
		.cpu2_voltage_code_pin(cpu2_voltage_code_pin), .throttle_interval(throttle_interval),
		.reg_req(reg_req), .reg_rsp_ff(reg_rsp_ff));
	cpu_pair_model cpu_pair_model_i (.alert1_on(a1), .alert2_on(a2), .code1(code1), .code2(code2),
		.cpu1_throttle_alert_n(cpu1_throttle_alert_n), .cpu2_throttle_alert_n(cpu2_throttle_alert_n),
		.cpu1_voltage_code_pin(cpu1_voltage_code_pin), .cpu2_voltage_code_pin(cpu2_voltage_code_pin));

	// Free-running clock, 5 ns period.
	initial
	begin
		forever #2.5 core_clk = ~core_clk;
	end

	// Compares an answer word with its expected value.
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	// Lets n clock edges pass, then steps off the edge.
	task automatic cycles(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// One read; the answer is valid one cycle after the request edge.
	task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
		@(posedge core_clk);
		#1;
		reg_req.rd = 1'b1;
		reg_req.addr = addr;
		cycles(1);
		reg_req.rd = 1'b0;
		check(reg_rsp_ff, {1'b1, exp});
	endtask

	// One write strobe.
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge core_clk);
		#1;
		reg_req.wr = 1'b1;
		reg_req.addr = addr;
		reg_req.wdata = data;
		cycles(1);
		reg_req.wr = 1'b0;
	endtask

	// Restarts both channels, throttles processor 1 for l1 clocks from s1, then checks one interval.
	task automatic run_interval(input logic [7:0] ivl, input int s1, input int l1, input logic on2,
		input logic [7:0] waddr, input logic [7:0] c1, input logic [7:0] c2);
		int n;
		n = 256 * (int'(ivl) + 1) + 20;
		throttle_interval = ivl;
		a2 = on2;
		cycles(8);
		wr(waddr, 8'hff);
		rd(`OFS_CPU1_DUTY_CUR, cur1_exp);
		rd(`OFS_CPU2_DUTY_CUR, cur2_exp);
		for (int i = 0; i < n; i++)
		begin
			a1 = (i >= s1) && (i < s1 + l1);
			cycles(1);
		end
		a2 = 1'b0;
		avg1_exp = 8'((9'(avg1_exp) + 9'(c1)) >> 1);
		avg2_exp = 8'((9'(avg2_exp) + 9'(c2)) >> 1);
		cur1_exp = c1;
		cur2_exp = c2;
		rd(`OFS_CPU1_DUTY_CUR, c1);
		rd(`OFS_CPU2_DUTY_CUR, c2);
		rd(`OFS_CPU1_DUTY_AVG, avg1_exp);
		rd(`OFS_CPU2_DUTY_AVG, avg2_exp);
	endtask

	// Prints the outcome and ends the run.
	task automatic print_verdict();
		if (fails == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Main sequence.
	initial
	begin
		cycles(2);
		reset = 1'b0;
		// Reset contents, unmapped places and inverted input levels.
		for (int a = 8'h66; a <= 8'h70; a++)
			rd(8'(a), (a == 8'h6b) ? 8'ha5 : 8'h00);
		input_level_n = 8'h0f;
		cycles(8);
		wr(`OFS_INPUT_LEVELS, 8'h00);
		rd(`OFS_INPUT_LEVELS, 8'hf0);
		// Partial duty, full duty, and a single short burst.
		run_interval(8'h00, 10, 64, 1'b0, `OFS_CPU2_DUTY_CUR, 8'h40, 8'h00);
		run_interval(8'h00, 0, 0, 1'b1, `OFS_CPU1_DUTY_CUR, 8'h00, 8'hff);
		run_interval(8'h0f, 80, 4, 1'b0, `OFS_CPU2_DUTY_CUR, 8'h01, 8'h00);
		// Voltage codes load only after holding still.
		code1 = 6'h2a;
		code2 = 6'h15;
		cycles(100);
		rd(`OFS_CPU1_VCODE, 8'h00);
		code1 = 6'h33;
		cycles(100);
		wr(`OFS_CPU2_VCODE, 8'hff);
		rd(`OFS_CPU1_VCODE, 8'h00);
		rd(`OFS_CPU2_VCODE, 8'h15);
		cycles(40);
		rd(`OFS_CPU1_VCODE, 8'h33);
		print_verdict();
	end
endmodule
